// *** rtl/twcp_defs.svh ***
// Register offsets, field positions and reset values of the timer
// What this block does
// - With event counting on, the counter advances on input events, not prescaled ticks.
// - Counter counts prescaled clock ticks in the selected direction until top or bottom.
// - Counting up, a count equal to top wraps to zero on the next tick.
// - Counting down, reaching bottom reloads the counter from the period register, or from match zero in frequency mode.
// - A software count write acts at once and beats any count, clear or reload.
// - Direction may change while running; counting continues in the new direction.
// - Period and match registers have shadows; each shadow has a valid flag.
// - Match registers and shadows are both writable; direct writes bypass buffering.
// - An unbuffered period write takes effect immediately.
// - A period written below the count while counting up makes the counter wrap.
// - A buffered period loads only on an update; its shadow is writable anytime.
// - Count equal to a match value sets that channel flag one clock after the next tick.
// - On update, valid match shadows copy in and compare from the next count.
// - A wave output overrides its pin only in a waveform mode with channel enabled.
// - Frequency mode takes period from match zero; channels toggle on each match.
// - Frequency mode, no prescale, match zero at zero: output toggles every clock.
// - Channels one and two add outputs sharing the match zero period.
// - Single-slope mode counts up and restarts; outputs set at bottom, clear on match.
// - Single-slope match at bottom holds output low; above top holds it high.
// - Bottom is a count of zero; top is the highest value of the sequence.
// - The update occurs at the sequence end; valid shadows copy unless locked.
// - Waveform changes from top, bottom or match appear one tick later; match flags one clock after that.
`ifndef TWCP_DEFS_SVH
`define TWCP_DEFS_SVH
`define TWCP_OFS_CTRL 8'h00
`define TWCP_OFS_WAVE 8'h04
`define TWCP_OFS_CONTROL_REG_E 8'h08
`define TWCP_OFS_FLAGS 8'h0C
`define TWCP_OFS_EVCTL 8'h10
`define TWCP_OFS_CNT 8'h14
`define TWCP_OFS_PER 8'h18
`define TWCP_OFS_CYCLE_LENGTH_SHADOW 8'h1C
`define TWCP_OFS_CMP_BASE 8'h20
`define TWCP_OFS_STAT 8'h2C
`define TWCP_OFS_CBUF_BASE 8'h30
`define TWCP_F_EN 0
`define TWCP_F_TICK_DIVIDER_SELECT_LSB 1
`define TWCP_F_WG_LSB 0
`define TWCP_F_CMPEN_LSB 4
`define TWCP_F_DIR 0
`define TWCP_F_UPDATE_LOCK 1
`define TWCP_F_CNTEI 0
`define TWCP_F_MFLAG_LSB 4
`define TWCP_RST_CNT 16'h0000
`define TWCP_RST_PER 16'hFFFF
`define TWCP_RST_CMP 16'h0000
`endif

// *** rtl/twcp_pkg.sv ***
// Types shared by the timer modules
package twcp_pkg;
	typedef enum logic [1:0] {
		TWCP_WG_NORMAL = 2'b00,
		TWCP_WG_FRQ = 2'b01,
		TWCP_WG_SS = 2'b11
	} twcp_wg_e;
endpackage

// *** rtl/twcp_cnt_if.sv ***
// Count state carried from the counter core to the compare channels
`timescale 1ns/1ps
`default_nettype none
interface twcp_cnt_if;
	logic tick;
	logic restart;
	logic [15:0] count;
	twcp_pkg::twcp_wg_e waveform_kind_select;
	modport ctl (output tick, output restart, output count, output waveform_kind_select);
	modport chan (input tick, input restart, input count, input waveform_kind_select);
endinterface
`default_nettype wire

// *** rtl/twcp_prescaler.sv ***
// Clock prescaler producing one-cycle count ticks
`timescale 1ns/1ps
`default_nettype none
module twcp_prescaler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic [2:0] tick_divider_select_i,
	output logic tick_o
);
	logic [9:0] div_r;
	wire [9:0] mask_w;

	// Divide by 1, 2, 4, 8, 16, 64, 256, 1024
	function automatic logic [9:0] twcp_div_mask(input logic [2:0] sel);
		case (sel)
			3'h0: return 10'h000;
			3'h1: return 10'h001;
			3'h2: return 10'h003;
			3'h3: return 10'h007;
			3'h4: return 10'h00F;
			3'h5: return 10'h03F;
			3'h6: return 10'h0FF;
			default: return 10'h3FF;
		endcase
	endfunction

	assign mask_w = twcp_div_mask(tick_divider_select_i);
	assign tick_o = enable_i && ((div_r & mask_w) == mask_w);

	// Held at zero while disabled so the first period after enable is full
	always_ff @(posedge clk_i)
		if (rst_i || !enable_i)
			div_r <= 10'h000;
		else
			div_r <= div_r + 10'h001;
endmodule
`default_nettype wire

// *** rtl/twcp_channel.sv ***
// One compare channel: match detection and waveform output
`timescale 1ns/1ps
`default_nettype none
module twcp_channel (
	input wire logic clk_i,
	input wire logic rst_i,
	twcp_cnt_if.chan cnt_if,
	input wire logic [15:0] match_value_i,
	output logic wave_o,
	output logic match_o
);
	logic wave_nxt;
	wire hit_w;

	assign hit_w = cnt_if.tick && (cnt_if.count == match_value_i);

	// Output changes land one tick after the count met its trigger
	always_comb
	begin
		wave_nxt = wave_o;
		case (cnt_if.waveform_kind_select)
			twcp_pkg::TWCP_WG_FRQ:
				if (hit_w)
					wave_nxt = !wave_o;
			twcp_pkg::TWCP_WG_SS:
				if (cnt_if.restart)
					wave_nxt = (match_value_i != 16'h0000);
				else if (hit_w)
					wave_nxt = 1'b0;
			default:
				wave_nxt = wave_o;
		endcase
	end

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			wave_o <= 1'b0;
			match_o <= 1'b0;
		end
		else
		begin
			wave_o <= wave_nxt;
			match_o <= hit_w;
		end

	property p_frq_toggle;
		@(posedge clk_i) disable iff (rst_i)
		(cnt_if.waveform_kind_select == twcp_pkg::TWCP_WG_FRQ) && hit_w |=> wave_o != $past(wave_o);
	endproperty
	a_frq_toggle: assert property (p_frq_toggle)
		else $error("frequency output did not toggle on match");

	property p_ss_zero_low;
		@(posedge clk_i) disable iff (rst_i)
		(cnt_if.waveform_kind_select == twcp_pkg::TWCP_WG_SS) && cnt_if.restart
			&& match_value_i == 16'h0000 |=> !wave_o;
	endproperty
	a_ss_zero_low: assert property (p_ss_zero_low)
		else $error("single-slope output set with zero match value");
endmodule
`default_nettype wire

// *** rtl/twcp_top.sv ***
// Sixteen-bit timer with buffered period, compare channels and wave outputs
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "twcp_defs.svh"
module twcp_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic event_a_i,
	output logic [2:0] wave_out_o,
	output logic [2:0] wave_override_o
);
	// Bus state
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_mux_w;
	wire req_w;
	wire wr_w;
	wire [7:0] badr_w;

	// Control registers
	logic en_r;
	logic [2:0] tick_divider_select_r;
	twcp_pkg::twcp_wg_e waveform_kind_select_r;
	logic [2:0] cmpen_r;
	logic dir_r;
	logic update_lock_r;
	logic evcnt_r;

	// Counter, period and compare storage
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [15:0] per_r;
	logic [15:0] per_nxt;
	logic [15:0] cycle_length_shadow_r;
	logic cycle_shadow_valid_r;
	logic [15:0] cmp_r [0:2];
	logic [15:0] cmp_nxt [0:2];
	logic [15:0] cmpbuf_r [0:2];
	logic [2:0] cmpbv_r;
	logic [2:0] mflag_r;

	// Decoded strobes and counter status
	wire wr_ctrl_w;
	wire wr_wave_w;
	wire wr_control_reg_e_w;
	wire wr_evctl_w;
	wire wr_cnt_w;
	wire wr_per_w;
	wire wr_pbuf_w;
	wire wr_stat_w;
	wire [2:0] wr_cmp_w;
	wire [2:0] wr_cbuf_w;
	wire [2:0] match_w;
	wire [2:0] wave_w;
	wire ptick_w;
	wire tick_w;
	wire down_w;
	wire [15:0] top_w;
	wire at_end_w;
	wire upd_w;

	twcp_cnt_if cif ();

	// Byte-lane merge for the 16-bit registers; upper lanes are ignored
	function automatic logic [15:0] twcp_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// Channel register address from a base and channel number
	function automatic logic [7:0] twcp_ch_adr(input logic [7:0] base, input logic [1:0] n);
		return base + {4'h0, n, 2'b00};
	endfunction

	// Wishbone classic: one wait state, ack stands one cycle
	assign req_w = cyc_i && stb_i;
	assign wr_w = req_w && we_i && ack_r;
	assign badr_w = {adr_i[7:2], 2'b00};
	assign ack_o = ack_r;
	assign dat_o = dat_r;

	// Write strobes fire on the acknowledge edge, when the master samples ack
	assign wr_ctrl_w = wr_w && (badr_w == `TWCP_OFS_CTRL);
	assign wr_wave_w = wr_w && (badr_w == `TWCP_OFS_WAVE);
	assign wr_control_reg_e_w = wr_w && (badr_w == `TWCP_OFS_CONTROL_REG_E);
	assign wr_evctl_w = wr_w && (badr_w == `TWCP_OFS_EVCTL);
	assign wr_cnt_w = wr_w && (badr_w == `TWCP_OFS_CNT);
	assign wr_per_w = wr_w && (badr_w == `TWCP_OFS_PER);
	assign wr_pbuf_w = wr_w && (badr_w == `TWCP_OFS_CYCLE_LENGTH_SHADOW);
	assign wr_stat_w = wr_w && (badr_w == `TWCP_OFS_STAT);

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_ch
			assign wr_cmp_w[g] = wr_w && (badr_w == twcp_ch_adr(`TWCP_OFS_CMP_BASE, 2'(g)));
			assign wr_cbuf_w[g] = wr_w && (badr_w == twcp_ch_adr(`TWCP_OFS_CBUF_BASE, 2'(g)));
			twcp_channel u_chan (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.cnt_if(cif.chan),
				.match_value_i(cmp_r[g]),
				.wave_o(wave_w[g]),
				.match_o(match_w[g])
			);
		end
	endgenerate

	// Read mux; unmapped addresses answer zero
	always_comb
	begin
		if (badr_w == `TWCP_OFS_CTRL)
			rd_mux_w = {28'h0000000, tick_divider_select_r, en_r};
		else if (badr_w == `TWCP_OFS_WAVE)
			rd_mux_w = {25'h0000000, cmpen_r, 2'b00, waveform_kind_select_r};
		else if (badr_w == `TWCP_OFS_CONTROL_REG_E)
			rd_mux_w = {30'h00000000, update_lock_r, dir_r};
		else if (badr_w == `TWCP_OFS_FLAGS)
			rd_mux_w = {28'h0000000, cmpbv_r, cycle_shadow_valid_r};
		else if (badr_w == `TWCP_OFS_EVCTL)
			rd_mux_w = {31'h00000000, evcnt_r};
		else if (badr_w == `TWCP_OFS_CNT)
			rd_mux_w = {16'h0000, cnt_r};
		else if (badr_w == `TWCP_OFS_PER)
			rd_mux_w = {16'h0000, per_r};
		else if (badr_w == `TWCP_OFS_CYCLE_LENGTH_SHADOW)
			rd_mux_w = {16'h0000, cycle_length_shadow_r};
		else if (badr_w == `TWCP_OFS_STAT)
			rd_mux_w = {25'h0000000, mflag_r, 1'b0, wave_w};
		else if (badr_w == twcp_ch_adr(`TWCP_OFS_CMP_BASE, 2'h0))
			rd_mux_w = {16'h0000, cmp_r[0]};
		else if (badr_w == twcp_ch_adr(`TWCP_OFS_CMP_BASE, 2'h1))
			rd_mux_w = {16'h0000, cmp_r[1]};
		else if (badr_w == twcp_ch_adr(`TWCP_OFS_CMP_BASE, 2'h2))
			rd_mux_w = {16'h0000, cmp_r[2]};
		else if (badr_w == twcp_ch_adr(`TWCP_OFS_CBUF_BASE, 2'h0))
			rd_mux_w = {16'h0000, cmpbuf_r[0]};
		else if (badr_w == twcp_ch_adr(`TWCP_OFS_CBUF_BASE, 2'h1))
			rd_mux_w = {16'h0000, cmpbuf_r[1]};
		else if (badr_w == twcp_ch_adr(`TWCP_OFS_CBUF_BASE, 2'h2))
			rd_mux_w = {16'h0000, cmpbuf_r[2]};
		else
			rd_mux_w = 32'h00000000;
	end

	// Read data is captured with the first request edge and held through ack
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end
		else
		begin
			ack_r <= req_w && !ack_r;
			if (req_w && !ack_r)
				dat_r <= rd_mux_w;
		end

	// Tick source: prescaled clock or event input
	twcp_prescaler u_presc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(en_r),
		.tick_divider_select_i(tick_divider_select_r),
		.tick_o(ptick_w)
	);
	assign tick_w = en_r && (evcnt_r ? event_a_i : ptick_w);

	// Single-slope runs upward only, whatever the direction bit says
	assign down_w = dir_r && (waveform_kind_select_r != twcp_pkg::TWCP_WG_SS);
	assign top_w = (waveform_kind_select_r == twcp_pkg::TWCP_WG_FRQ) ? cmp_r[0] : per_r;
	// Greater-or-equal so a period lowered below the count still wraps
	assign at_end_w = down_w ? (cnt_r == 16'h0000) : (cnt_r >= top_w);
	assign upd_w = tick_w && at_end_w && !update_lock_r;

	assign cif.tick = tick_w;
	// Bottom tick: the set lands as the count leaves zero, one tick after bottom
	assign cif.restart = tick_w && (cnt_r == 16'h0000) && !down_w;
	assign cif.count = cnt_r;
	assign cif.waveform_kind_select = waveform_kind_select_r;

	// Counter next value; a software write wins over counting
	always_comb
	begin
		if (wr_cnt_w)
			cnt_nxt = twcp_merge(cnt_r, dat_i, sel_i);
		else if (tick_w && at_end_w)
			cnt_nxt = down_w ? top_w : 16'h0000;
		else if (tick_w)
			cnt_nxt = down_w ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
		else
			cnt_nxt = cnt_r;
	end

	// Period and compares: direct writes act at once, shadows copy on update
	always_comb
	begin
		if (wr_per_w)
			per_nxt = twcp_merge(per_r, dat_i, sel_i);
		else if (upd_w && cycle_shadow_valid_r)
			per_nxt = cycle_length_shadow_r;
		else
			per_nxt = per_r;
		for (int i = 0; i < 3; i++)
		begin
			if (wr_cmp_w[i])
				cmp_nxt[i] = twcp_merge(cmp_r[i], dat_i, sel_i);
			else if (upd_w && cmpbv_r[i])
				cmp_nxt[i] = cmpbuf_r[i];
			else
				cmp_nxt[i] = cmp_r[i];
		end
	end

	// Control registers
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			en_r <= 1'b0;
			tick_divider_select_r <= 3'h0;
			waveform_kind_select_r <= twcp_pkg::TWCP_WG_NORMAL;
			cmpen_r <= 3'h0;
			dir_r <= 1'b0;
			update_lock_r <= 1'b0;
			evcnt_r <= 1'b0;
		end
		else
		begin
			if (wr_ctrl_w)
			begin
				en_r <= dat_i[`TWCP_F_EN];
				tick_divider_select_r <= dat_i[`TWCP_F_TICK_DIVIDER_SELECT_LSB +: 3];
			end
			if (wr_wave_w)
			begin
				waveform_kind_select_r <= twcp_pkg::twcp_wg_e'(dat_i[`TWCP_F_WG_LSB +: 2]);
				cmpen_r <= dat_i[`TWCP_F_CMPEN_LSB +: 3];
			end
			if (wr_control_reg_e_w)
			begin
				dir_r <= dat_i[`TWCP_F_DIR];
				update_lock_r <= dat_i[`TWCP_F_UPDATE_LOCK];
			end
			if (wr_evctl_w)
				evcnt_r <= dat_i[`TWCP_F_CNTEI];
		end

	// Counter and buffered registers; a shadow write in the update cycle keeps valid
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			cnt_r <= `TWCP_RST_CNT;
			per_r <= `TWCP_RST_PER;
			cycle_length_shadow_r <= `TWCP_RST_CMP;
			cycle_shadow_valid_r <= 1'b0;
			cmpbv_r <= 3'h0;
			mflag_r <= 3'h0;
			for (int i = 0; i < 3; i++)
			begin
				cmp_r[i] <= `TWCP_RST_CMP;
				cmpbuf_r[i] <= `TWCP_RST_CMP;
			end
		end
		else
		begin
			cnt_r <= cnt_nxt;
			per_r <= per_nxt;
			if (wr_pbuf_w)
				cycle_length_shadow_r <= twcp_merge(cycle_length_shadow_r, dat_i, sel_i);
			cycle_shadow_valid_r <= wr_pbuf_w || (cycle_shadow_valid_r && !upd_w);
			cmpbv_r <= wr_cbuf_w | (cmpbv_r & ~{3{upd_w}});
			// Match flags clear by writing one; a new match in that cycle wins
			mflag_r <= match_w | (mflag_r & ~({3{wr_stat_w}} & dat_i[`TWCP_F_MFLAG_LSB +: 3]));
			for (int i = 0; i < 3; i++)
			begin
				cmp_r[i] <= cmp_nxt[i];
				if (wr_cbuf_w[i])
					cmpbuf_r[i] <= twcp_merge(cmpbuf_r[i], dat_i, sel_i);
			end
		end

	// Pin override only in a waveform mode with the channel enabled
	assign wave_out_o = wave_w;
	assign wave_override_o = cmpen_r & {3{waveform_kind_select_r == twcp_pkg::TWCP_WG_FRQ
		|| waveform_kind_select_r == twcp_pkg::TWCP_WG_SS}};

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_up_at_top;
		tick_w && !down_w && cnt_r >= top_w && !wr_cnt_w;
	endsequence
	sequence s_down_at_bottom;
		tick_w && down_w && cnt_r == 16'h0000 && !wr_cnt_w;
	endsequence

	property p_wrap_up;
		s_up_at_top |=> cnt_r == 16'h0000;
	endproperty
	a_wrap_up: assert property (p_wrap_up)
		else $error("counter did not wrap to zero after top");

	property p_reload_down;
		s_down_at_bottom |=> cnt_r == $past(top_w);
	endproperty
	a_reload_down: assert property (p_reload_down)
		else $error("counter not reloaded with period at bottom");

	property p_step_up;
		tick_w && !down_w && cnt_r < top_w && !wr_cnt_w |=> cnt_r == $past(cnt_r) + 16'h0001;
	endproperty
	a_step_up: assert property (p_step_up)
		else $error("counter did not step up on tick");

	property p_step_down;
		tick_w && down_w && cnt_r != 16'h0000 && !wr_cnt_w |=> cnt_r == $past(cnt_r) - 16'h0001;
	endproperty
	a_step_down: assert property (p_step_down)
		else $error("counter did not step down on tick");

	property p_event_hold;
		en_r && evcnt_r && !event_a_i && !wr_cnt_w |=> $stable(cnt_r);
	endproperty
	a_event_hold: assert property (p_event_hold)
		else $error("counter moved without an event");

	property p_cnt_write;
		wr_cnt_w && sel_i[1:0] == 2'b11 |=> cnt_r == $past(dat_i[15:0]);
	endproperty
	a_cnt_write: assert property (p_cnt_write)
		else $error("count write did not take priority");

	property p_per_hold;
		!wr_per_w && !(upd_w && cycle_shadow_valid_r) |=> $stable(per_r);
	endproperty
	a_per_hold: assert property (p_per_hold)
		else $error("period changed outside write or update");

	property p_per_copy;
		upd_w && cycle_shadow_valid_r && !wr_per_w |=> per_r == $past(cycle_length_shadow_r) && (cycle_shadow_valid_r == $past(wr_pbuf_w));
	endproperty
	a_per_copy: assert property (p_per_copy)
		else $error("period shadow not copied on update");

	property p_bv_set;
		wr_pbuf_w |=> cycle_shadow_valid_r;
	endproperty
	a_bv_set: assert property (p_bv_set)
		else $error("period shadow valid flag not set");

	property p_cmp_copy;
		upd_w && cmpbv_r[0] && !wr_cmp_w[0] |=> cmp_r[0] == $past(cmpbuf_r[0]);
	endproperty
	a_cmp_copy: assert property (p_cmp_copy)
		else $error("match shadow not copied on update");

	property p_flag_set;
		tick_w && cnt_r == cmp_r[1] |=> ##1 mflag_r[1];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("match flag not set after compare match");
endmodule
`default_nettype wire

// *** tb/tb_timer_with_compare_pwm.sv ***
// Self-checking bench for the timer with buffered period and wave outputs
`timescale 1ns/1ps
`default_nettype none
`include "twcp_defs.svh"
module tb_timer_with_compare_pwm;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h00000000;
	logic we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic ev = 1'b0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [2:0] wave_out_o;
	logic [2:0] wave_override_o;
	int err_count = 0;
	int checks = 0;
	logic [31:0] rd;
	logic [15:0] cnt_m;
	logic [15:0] top_m;
	logic [15:0] shd_m;
	logic dir_m;
	int hi_n[3];
	int tg_n[3];
	int k;

	twcp_top u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.adr_i(adr),
		.dat_i(wdat),
		.dat_o(dat_o),
		.we_i(we),
		.sel_i(sel),
		.cyc_i(cyc),
		.stb_i(stb),
		.ack_o(ack_o),
		.event_a_i(ev),
		.wave_out_o(wave_out_o),
		.wave_override_o(wave_override_o)
	);

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Classic cycle; the request stays put until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20)
			chk("ack", {31'h0, ack_o}, 32'h00000001);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(what, q, exp);
	endtask

	// Event held high for n edges counts exactly n ticks
	task automatic pulse(input int n);
		@(posedge clk_i);
		ev <= 1'b1;
		repeat (n) @(posedge clk_i);
		ev <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// Expected count after one tick
	function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] t, input logic d);
		if (d)
			return (c == 16'h0000) ? t : c - 16'h0001;
		return (c >= t) ? 16'h0000 : c + 16'h0001;
	endfunction

	// Counts high cycles and toggles of each wave output
	task automatic watch(input int len);
		logic [2:0] prev;
		@(posedge clk_i);
		prev = wave_out_o;
		for (int i = 0; i < 3; i++)
		begin
			hi_n[i] = 0;
			tg_n[i] = 0;
		end
		repeat (len)
		begin
			@(posedge clk_i);
			for (int i = 0; i < 3; i++)
			begin
				hi_n[i] += int'(wave_out_o[i] === 1'b1);
				tg_n[i] += int'(wave_out_o[i] !== prev[i]);
			end
			prev = wave_out_o;
		end
	endtask

	// Watchdog sized well above the expected run length
	initial
	begin
		#1000000;
		err_count++;
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(32'h520B));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset state and an unmapped place
		chk("wave", {29'h0, wave_out_o}, 32'h0);
		chk("override", {29'h0, wave_override_o}, 32'h0);
		rchk("count", `TWCP_OFS_CNT, 32'h0);
		rchk("period", `TWCP_OFS_PER, 32'h0000FFFF);
		rchk("match1", `TWCP_OFS_CMP_BASE + 8'h04, 32'h0);
		rchk("flags", `TWCP_OFS_FLAGS, 32'h0);
		rchk("ctrl", `TWCP_OFS_CTRL, 32'h0);
		wr(8'hFC, 32'h0000FFFF);
		rchk("unmapped", 8'hFC, 32'h0);
		// Event counting, random period, runs and direction changes
		wr(`TWCP_OFS_CMP_BASE, 32'h8000);
		wr(`TWCP_OFS_CMP_BASE + 8'h08, 32'h8000);
		wr(`TWCP_OFS_EVCTL, 32'h1);
		// At least 8 so the later match at 7 is reached inside one period
		top_m = 16'($urandom_range(8, 40));
		wr(`TWCP_OFS_PER, {16'h0, top_m});
		rchk("period", `TWCP_OFS_PER, {16'h0, top_m});
		wr(`TWCP_OFS_CTRL, 32'h1);
		wr(`TWCP_OFS_CONTROL_REG_E, 32'h1);
		pulse(1);
		rchk("reload", `TWCP_OFS_CNT, {16'h0, top_m});
		cnt_m = top_m;
		repeat (6)
		begin
			dir_m = 1'($urandom_range(0, 1));
			wr(`TWCP_OFS_CONTROL_REG_E, {31'h0, dir_m});
			k = $urandom_range(1, 50);
			pulse(k);
			repeat (k) cnt_m = step(cnt_m, top_m, dir_m);
			rchk("event count", `TWCP_OFS_CNT, {16'h0, cnt_m});
		end
		wr(`TWCP_OFS_CONTROL_REG_E, 32'h0);
		wr(`TWCP_OFS_CNT, 32'h0100);
		rchk("count write", `TWCP_OFS_CNT, 32'h0100);
		pulse(1);
		rchk("wrap above top", `TWCP_OFS_CNT, 32'h0);
		// Buffered period, then the same with the update locked
		shd_m = top_m + 16'h0003;
		wr(`TWCP_OFS_CYCLE_LENGTH_SHADOW, {16'h0, shd_m});
		rchk("period valid", `TWCP_OFS_FLAGS, 32'h1);
		pulse(int'(top_m));
		rchk("period held", `TWCP_OFS_PER, {16'h0, top_m});
		pulse(1);
		rchk("period loaded", `TWCP_OFS_PER, {16'h0, shd_m});
		rchk("valid cleared", `TWCP_OFS_FLAGS, 32'h0);
		wr(`TWCP_OFS_CONTROL_REG_E, 32'h2);
		wr(`TWCP_OFS_CYCLE_LENGTH_SHADOW, {16'h0, top_m});
		pulse(int'(shd_m) + 1);
		rchk("locked period", `TWCP_OFS_PER, {16'h0, shd_m});
		rchk("locked valid", `TWCP_OFS_FLAGS, 32'h1);
		// Match flag, clear, and a buffered match value
		wr(`TWCP_OFS_CONTROL_REG_E, 32'h0);
		wr(`TWCP_OFS_PER, 32'h14);
		wr(`TWCP_OFS_CMP_BASE + 8'h04, 32'h3);
		rchk("match1", `TWCP_OFS_CMP_BASE + 8'h04, 32'h3);
		wr(`TWCP_OFS_CNT, 32'h0);
		wr(`TWCP_OFS_STAT, 32'h70);
		pulse(5);
		bus(1'b0, `TWCP_OFS_STAT, 32'h0, rd);
		chk("match flags", {29'h0, rd[6:4]}, 32'h2);
		wr(`TWCP_OFS_STAT, 32'h20);
		bus(1'b0, `TWCP_OFS_STAT, 32'h0, rd);
		chk("flag clear", {29'h0, rd[6:4]}, 32'h0);
		wr(`TWCP_OFS_CBUF_BASE + 8'h04, 32'h7);
		// Period shadow is still valid from the locked run
		rchk("match valid", `TWCP_OFS_FLAGS, 32'h5);
		rchk("match not yet", `TWCP_OFS_CMP_BASE + 8'h04, 32'h3);
		wr(`TWCP_OFS_CNT, 32'h0);
		pulse(21);
		rchk("match loaded", `TWCP_OFS_CMP_BASE + 8'h04, 32'h7);
		wr(`TWCP_OFS_STAT, 32'h70);
		pulse(8);
		bus(1'b0, `TWCP_OFS_STAT, 32'h0, rd);
		chk("new match", {29'h0, rd[6:4]}, 32'h2);
		// Frequency mode across dividers and periods
		wr(`TWCP_OFS_EVCTL, 32'h0);
		wr(`TWCP_OFS_WAVE, 32'h72);
		@(posedge clk_i);
		chk("no wave mode", {29'h0, wave_override_o}, 32'h0);
		for (int dv = 0; dv < 5; dv++)
			for (int m = 0; m < 4; m += 3)
			begin
				wr(`TWCP_OFS_CTRL, 32'h0);
				wr(`TWCP_OFS_CMP_BASE, 32'(m));
				wr(`TWCP_OFS_CMP_BASE + 8'h04, 32'(m));
				wr(`TWCP_OFS_WAVE, 32'h71);
				@(posedge clk_i);
				chk("override", {29'h0, wave_override_o}, 32'h7);
				wr(`TWCP_OFS_CNT, 32'h0);
				wr(`TWCP_OFS_CTRL, {28'h0, 3'(dv), 1'b1});
				k = (1 << dv) * (m + 1);
				repeat (2 * k + 4) @(posedge clk_i);
				watch(16 * k);
				chk("freq ch0", 32'(tg_n[0]), 32'd16);
				chk("freq ch1", 32'(tg_n[1]), 32'd16);
				chk("freq ch2", 32'(tg_n[2]), 32'd0);
			end
		// Single-slope: low, high and a 4 of 10 duty
		wr(`TWCP_OFS_CTRL, 32'h0);
		wr(`TWCP_OFS_PER, 32'h9);
		wr(`TWCP_OFS_CMP_BASE, 32'h0);
		wr(`TWCP_OFS_CMP_BASE + 8'h04, 32'hA);
		wr(`TWCP_OFS_CMP_BASE + 8'h08, 32'h4);
		wr(`TWCP_OFS_WAVE, 32'h53);
		@(posedge clk_i);
		chk("override", {29'h0, wave_override_o}, 32'h5);
		wr(`TWCP_OFS_CNT, 32'h0);
		wr(`TWCP_OFS_CTRL, 32'h1);
		repeat (24) @(posedge clk_i);
		watch(40);
		chk("pwm low", 32'(hi_n[0]), 32'd0);
		chk("pwm high", 32'(hi_n[1]), 32'd40);
		chk("pwm duty", 32'(hi_n[2]), 32'd16);
		tally_and_finish();
	end
endmodule
`default_nettype wire
